// ==== include/lfc_defines.svh ====
// lcd frame clock and contrast: offsets, fields, reset values
// assumes inclusion by bare name from the design file
`ifndef LFC_DEFINES_SVH
`define LFC_DEFINES_SVH
`define LFC_ADDR_FRAME_RATE 4'h0
`define LFC_ADDR_CONTRAST   4'h4
`define LFC_ADDR_CONTROL    4'h8
`define LFC_ADDR_STATUS     4'hc
`define LFC_FRR_MASK        8'h77
`define LFC_CCR_MASK        8'h0f
`define LFC_CTL_MASK        8'h31
`define LFC_RESET_BYTE      8'h00
`define LFC_K_THIRD         4'h6
`define LFC_K_OTHER         4'h8
`define LFC_DUTY_THIRD      2'h2
`define LFC_RESP_OKAY       2'h0
`define LFC_RESP_SLVERR     2'h2
`endif

// ==== include/lfc_pkg.sv ====
// lcd frame clock and contrast: shared types
// assumes lfc_defines.svh on the include path
package lfc_pkg;
  typedef logic [11:0] lfc_tap_t;
  typedef logic [3:0]  lfc_code_t;
endpackage

// ==== sim/lfc_frame_clock_assertions.sv ====
// port checks for lfc_frame_clock
// assumes bind onto every instance
`timescale 1ns/1ps
`default_nettype none
module lfc_frame_clock_checker
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        o_frame_clk_tick,
  input wire logic        o_frame_start,
  input wire logic [3:0]  o_contrast_code
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_code_at_frame: assert property
    ($changed(o_contrast_code) |-> o_frame_start)
    else $error("contrast moved off frame start");
  a_start_pulse: assert property
    (o_frame_start |=> !o_frame_start)
    else $error("frame start longer than one cycle");
  a_start_on_tick: assert property
    (o_frame_start |-> o_frame_clk_tick)
    else $error("frame start without frame clock step");
  a_reset_clear: assert property
    ($past(i_rst) |-> !o_frame_start && o_contrast_code == 4'h0)
    else $error("outputs not clear after reset");
  a_bvalid_hold: assert property
    ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write answer dropped");
  a_bresp_hold: assert property
    ($changed(s_axi_bresp) |-> s_axi_bvalid)
    else $error("write response moved without answer");
  a_rvalid_hold: assert property
    ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read answer dropped");
  a_rdata_hold: assert property
    ($changed(s_axi_rdata) |-> s_axi_rvalid)
    else $error("read data moved without answer");
  a_rdata_upper: assert property
    (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_answer: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_block: assert property
    (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  c_frame: cover property (o_frame_start);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind lfc_frame_clock lfc_frame_clock_checker u_chk (.i_clk, .i_rst,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .o_frame_clk_tick,
  .o_frame_start, .o_contrast_code);
`default_nettype wire

// ==== sim/lfc_frame_clock_bench.sv ====
// bench for lfc_frame_clock: registers, contrast latch, frame period
// assumes glass model and bound checker compiled first
`timescale 1ns/1ps
`default_nettype none
module lfc_frame_clock_bench import lfc_pkg::*;;
  logic        i_clk, i_rst, i_ext_clk_tick, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        o_frame_clk_tick, o_frame_start;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rq[$];
  logic [1:0]  s_axi_bresp, s_axi_rresp, ph, du;
  logic [2:0]  t, d;
  logic [11:0] mv;
  lfc_code_t   o_contrast_code, c, prev, cq[$];
  int          bad_count, checks, cnt, tcnt, k, p, fq[$], kq[$];
  lfc_frame_clock dut (.i_clk, .i_rst, .i_ext_clk_tick, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .o_frame_clk_tick, .o_frame_start, .o_contrast_code);
  lfc_glass_model glass (.i_contrast_code(o_contrast_code), .o_drive_mv(mv));
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // ready raised with the request; one idle edge between calls
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    do
    begin
      @(posedge i_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, 32'h0);
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    s_axi_araddr  <= a;
    do
    begin
      @(posedge i_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  // skip the mixed frame after a change, then time one whole frame
  task automatic frame(input int per, input int ticks);
    @(posedge i_clk iff o_frame_start);
    @(posedge i_clk);
    fq.push_back(per);
    kq.push_back(ticks);
    @(posedge i_clk iff o_frame_start);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ph             <= 2'h0;
      i_ext_clk_tick <= 1'b0;
    end
    else
    begin
      ph             <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      i_ext_clk_tick <= (ph == 2'h1);
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      chk(s_axi_rdata, rq.pop_front());
      chk({30'h0, s_axi_rresp}, 32'h0);
    end
  end
  always @(negedge i_clk)
  begin
    if (o_frame_clk_tick) tcnt++;
    if (o_frame_start)
    begin
      if (fq.size() > 0) chk(cnt, fq.pop_front());
      if (kq.size() > 0) chk(tcnt, kq.pop_front());
      tcnt = 0;
      if (cq.size() > 0)
      begin
        chk(o_contrast_code, cq[0]);
        chk(mv, 12'ha28 + 12'h032 * cq[0]);
        void'(cq.pop_front());
      end
      cnt = 1;
    end
    else
      cnt++;
  end
  initial
  begin
    #2500000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    {i_rst, s_axi_wstrb, prev} = {1'b1, 4'h1, 4'h0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h0;
    s_axi_wdata = 32'h0;
    void'($urandom(32'h26a4));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'hc, 32'h0);
    wr(4'h0, 32'hff);
    rd(4'h0, 32'h77);
    // last pass runs from the external tick, one per three clocks
    // tap 7 pass kept at divide 1 so the run stays short
    for (int i = 0; i < 7; i++)
    begin
      c = lfc_code_t'($urandom);
      t = (i == 6) ? 3'h0 : (i == 2) ? 3'h7 : 3'(i % 3);
      d = (i == 0) ? 3'h7 : (i == 2) ? 3'h0 : 3'($urandom % 2);
      du = 2'(i);
      k = (du == 2'h2) ? 6 : 8;
      p = k * ((t == 3'h0) ? 16 : 32 << t) * ((i == 6) ? 3 : 1) * (1 + d);
      wr(4'h4, {24'h0, 4'hf, c});
      rd(4'h4, {28'h0, c});
      rd(4'hc, {28'h0, prev});
      cq.push_back(c);
      wr(4'h8, {26'h0, du, 3'h0, i == 6});
      wr(4'h0, {25'h0, t, 1'b1, d});
      frame(p, k);
      prev = c;
    end
    // mid-run reset must drop the contrast setting and the latched code
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(4'h4, 32'h0);
    rd(4'hc, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire

// ==== sim/lfc_glass_model.sv ====
// glass side: applied contrast code to peak drive millivolts
// assumes the code is already latched at frame start
`timescale 1ns/1ps
`default_nettype none
module lfc_glass_model
  import lfc_pkg::*;
(
  // applied code
  input  wire lfc_code_t i_contrast_code,
  // peak drive level
  output logic [11:0]    o_drive_mv
);
  always_comb o_drive_mv = 12'ha28 + 12'h032 * 12'(i_contrast_code);
endmodule
`default_nettype wire

// ==== verilog/lfc_frame_clock.sv ====
// lcd frame timing, contrast latch and axi4-lite register slave
// assumes i_ext_clk_tick synchronous one-cycle ticks of the external clock
`include "lfc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lfc_frame_clock
  import lfc_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // external source clock tick
  input  wire logic        i_ext_clk_tick,
  // axi4-lite write address, data and response
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // lcd side
  output logic             o_frame_clk_tick,
  output logic             o_frame_start,
  output logic [3:0]       o_contrast_code
);

  ////////////////////////////////////////////////////////////////////////////
  // last count of each tap: n minus one, so divide by 4096 fits 12 bits
  function automatic lfc_tap_t tap_last(input logic [2:0] sel);
    unique case (sel)
      3'd0: tap_last = 12'd15;
      3'd1: tap_last = 12'd63;
      3'd2: tap_last = 12'd127;
      3'd3: tap_last = 12'd255;
      3'd4: tap_last = 12'd511;
      3'd5: tap_last = 12'd1023;
      3'd6: tap_last = 12'd2047;
      3'd7: tap_last = 12'd4095;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  frame_rate_setting;
  logic [7:0]  contrast_setting;
  logic [7:0]  control;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_lane0;
  logic [12:0] pre_cnt;
  logic [2:0]  div_cnt;
  logic [3:0]  k_cnt;
  logic        frame_clk_tick;
  logic        frame_start;
  logic [3:0]  contrast_code;
  logic [7:0]  next_frame_rate_setting;
  logic [7:0]  next_contrast_setting;
  logic [7:0]  next_control;
  logic        next_aw_held;
  logic        next_w_held;
  logic [3:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic        next_w_lane0;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [12:0] next_pre_cnt;
  logic [2:0]  next_div_cnt;
  logic [3:0]  next_k_cnt;
  logic        next_frame_clk_tick;
  logic        next_frame_start;
  logic [3:0]  next_contrast_code;
  logic        next_awready;
  logic        next_wready;
  logic        next_arready;
  logic        src_tick;
  logic [12:0] n_last;
  logic [3:0]  k_last;

  ////////////////////////////////////////////////////////////////////////////
  // register slave
  always_comb
  begin
    next_frame_rate_setting = frame_rate_setting;
    next_contrast_setting   = contrast_setting;
    next_control            = control;
    next_aw_held            = aw_held;
    next_w_held             = w_held;
    next_aw_addr            = aw_addr;
    next_w_data             = w_data;
    next_w_lane0            = w_lane0;
    next_bvalid             = s_axi_bvalid;
    next_bresp              = s_axi_bresp;
    next_rvalid             = s_axi_rvalid;
    next_rdata              = s_axi_rdata;
    next_rresp              = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (aw_held && w_held && !s_axi_bvalid)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `LFC_RESP_OKAY;
      unique case (aw_addr)
        `LFC_ADDR_FRAME_RATE:
          if (w_lane0)
            next_frame_rate_setting = w_data[7:0] & `LFC_FRR_MASK;
        `LFC_ADDR_CONTRAST:
          if (w_lane0)
            next_contrast_setting = w_data[7:0] & `LFC_CCR_MASK;
        `LFC_ADDR_CONTROL:
          if (w_lane0)
            next_control = w_data[7:0] & `LFC_CTL_MASK;
        `LFC_ADDR_STATUS:
          next_bresp = `LFC_RESP_OKAY;
        default:
          next_bresp = `LFC_RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = `LFC_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `LFC_ADDR_FRAME_RATE: next_rdata[7:0] = frame_rate_setting;
        `LFC_ADDR_CONTRAST:   next_rdata[7:0] = contrast_setting;
        `LFC_ADDR_CONTROL:    next_rdata[7:0] = control;
        `LFC_ADDR_STATUS:     next_rdata[3:0] = contrast_code;
        default:              next_rresp      = `LFC_RESP_SLVERR;
      endcase
    end
    // readies from next state: one write and one read in flight
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      frame_rate_setting <= `LFC_RESET_BYTE;
      contrast_setting   <= `LFC_RESET_BYTE;
      control            <= `LFC_RESET_BYTE;
      aw_held            <= 1'b0;
      w_held             <= 1'b0;
      aw_addr            <= 4'h0;
      w_data             <= 32'h0000_0000;
      w_lane0            <= 1'b0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= 2'h0;
      s_axi_rvalid       <= 1'b0;
      s_axi_rdata        <= 32'h0000_0000;
      s_axi_rresp        <= 2'h0;
      s_axi_awready      <= 1'b1;
      s_axi_wready       <= 1'b1;
      s_axi_arready      <= 1'b1;
    end
    else
    begin
      frame_rate_setting <= next_frame_rate_setting;
      contrast_setting   <= next_contrast_setting;
      control            <= next_control;
      aw_held            <= next_aw_held;
      w_held             <= next_w_held;
      aw_addr            <= next_aw_addr;
      w_data             <= next_w_data;
      w_lane0            <= next_w_lane0;
      s_axi_bvalid       <= next_bvalid;
      s_axi_bresp        <= next_bresp;
      s_axi_rvalid       <= next_rvalid;
      s_axi_rdata        <= next_rdata;
      s_axi_rresp        <= next_rresp;
      s_axi_awready      <= next_awready;
      s_axi_wready       <= next_wready;
      s_axi_arready      <= next_arready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame timing
  always_comb
  begin
    src_tick = control[0] ? i_ext_clk_tick : 1'b1;
    n_last = {1'b0, tap_last(frame_rate_setting[6:4])};
    k_last = (control[5:4] == `LFC_DUTY_THIRD) ? `LFC_K_THIRD - 4'd1
                                               : `LFC_K_OTHER - 4'd1;
    next_pre_cnt        = pre_cnt;
    next_div_cnt        = div_cnt;
    next_k_cnt          = k_cnt;
    next_frame_clk_tick = 1'b0;
    next_frame_start    = 1'b0;
    next_contrast_code  = contrast_code;
    if (src_tick)
    begin
      if (pre_cnt >= n_last)
      begin
        next_pre_cnt = 13'd0;
        if (div_cnt >= frame_rate_setting[2:0])
        begin
          next_div_cnt        = 3'd0;
          next_frame_clk_tick = 1'b1;
          if (k_cnt >= k_last)
          begin
            next_k_cnt = 4'd0;
            next_frame_start = 1'b1;
            next_contrast_code = contrast_setting[3:0];
          end
          else
            next_k_cnt = k_cnt + 4'd1;
        end
        else
          next_div_cnt = div_cnt + 3'd1;
      end
      else
        next_pre_cnt = pre_cnt + 13'd1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pre_cnt        <= 13'd0;
      div_cnt        <= 3'd0;
      k_cnt          <= 4'd0;
      frame_clk_tick <= 1'b0;
      frame_start    <= 1'b0;
      contrast_code  <= 4'h0;
    end
    else
    begin
      pre_cnt        <= next_pre_cnt;
      div_cnt        <= next_div_cnt;
      k_cnt          <= next_k_cnt;
      frame_clk_tick <= next_frame_clk_tick;
      frame_start    <= next_frame_start;
      contrast_code  <= next_contrast_code;
    end
  end

  assign o_frame_clk_tick = frame_clk_tick;
  assign o_frame_start    = frame_start;
  assign o_contrast_code  = contrast_code;

endmodule
`default_nettype wire
